/* hdl/gpfw_fuse_word.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "gpfw_consts.svh"
// Contract
// RULE1: chip erase sets whole word to ones
// RULE2: shipped word is fc07ffff
// RULE3: enable codes 1,2 on; 1 resets
// RULE4: hysteresis bit one enables hysteresis
// RULE5: six level bits drive brownout threshold
// RULE6: boot protect field goes to flash
// RULE7: fetch lock bit one means unlocked
// RULE8: sixteen region lock bits go to flash
// RULE9: spare fuses 31..29 readable
// RULE10: consumers always see current fuse word
module gpfw_fuse_word #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              chip_erase,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output gpfw_pkg::gpfw_cfg_t    fuse_cfg
);
    gpfw_pkg::gpfw_apb_state_t state_reg;
    gpfw_pkg::gpfw_apb_state_t state_next;
    logic [31:0]               fuse_reg;
    logic [31:0]               fuse_next;
    logic                      erased_reg;
    logic                      erased_next;
    logic [31:0]               prdata_reg;
    logic [31:0]               prdata_next;
    logic                      pslverr_reg;
    logic                      pslverr_next;
    logic                      pready_reg;
    logic                      pready_next;
    gpfw_pkg::gpfw_cfg_t       cfg_reg;
    gpfw_pkg::gpfw_cfg_t       cfg_next;
    logic                      commit;
    logic                      wr_prog;
    logic                      wr_stat;

    // shipped word decoded like any other; a raw cast would mis-set enable
    localparam logic [31:0] SHIP_WORD = `GPFW_FUSE_SHIPPED;
    localparam logic [1:0]  SHIP_CODE =
        SHIP_WORD[`GPFW_BRN_EN_HI:`GPFW_BRN_EN_LO];
    localparam gpfw_pkg::gpfw_cfg_t CFG_SHIPPED = '{
        spare_fuses:            SHIP_WORD[`GPFW_SPARE_HI:`GPFW_SPARE_LO],
        brownout_enable:        (SHIP_CODE == `GPFW_BRN_RST)
                                || (SHIP_CODE == `GPFW_BRN_NORST),
        brownout_reset_enable:  (SHIP_CODE == `GPFW_BRN_RST),
        brownout_hysteresis:    SHIP_WORD[`GPFW_HYST_BIT],
        brownout_trigger_level: SHIP_WORD[`GPFW_LEVEL_HI:`GPFW_LEVEL_LO],
        boot_area_protect:      SHIP_WORD[`GPFW_BOOTP_HI:`GPFW_BOOTP_LO],
        ext_priv_fetch_lock:    SHIP_WORD[`GPFW_FLOCK_BIT],
        region_lock:            SHIP_WORD[`GPFW_LOCK_HI:`GPFW_LOCK_LO]
    };

    // access phase answered one cycle after it opens
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            gpfw_pkg::GPFW_IDLE: begin
                if (psel && penable) begin
                    state_next = gpfw_pkg::GPFW_ACK;
                end
            end
            gpfw_pkg::GPFW_ACK: begin
                state_next = gpfw_pkg::GPFW_IDLE;
            end
            default: begin
                state_next = gpfw_pkg::GPFW_IDLE;
            end
        endcase
        pready_next = (state_next == gpfw_pkg::GPFW_ACK);
    end

    assign commit  = (state_reg == gpfw_pkg::GPFW_ACK) && psel && penable;
    assign wr_prog = commit && pwrite
                     && (paddr == ADDR_W'(`GPFW_OFS_PROG));
    assign wr_stat = commit && pwrite
                     && (paddr == ADDR_W'(`GPFW_OFS_STAT));

    // programming only clears bits; only erase, or reset to the shipped word, brings bits back to ones
    always_comb begin
        fuse_next = fuse_reg;
        if (wr_prog) begin
            fuse_next = fuse_reg & pwdata;
        end
        if (chip_erase) begin
            fuse_next = `GPFW_FUSE_ERASED; // [RULE1]
        end
        erased_next = erased_reg;
        if (wr_stat && pwdata[`GPFW_STAT_ERASED]) begin
            erased_next = 1'b0;
        end
        if (chip_erase) begin
            erased_next = 1'b1; // set wins over clear
        end
    end

    always_comb begin
        prdata_next  = 32'h0;
        pslverr_next = 1'b0;
        if (psel && penable && state_reg == gpfw_pkg::GPFW_IDLE) begin
            if (paddr == ADDR_W'(`GPFW_OFS_FUSE)) begin
                prdata_next  = fuse_reg; // [RULE9]
                pslverr_next = pwrite;
            end else if (paddr == ADDR_W'(`GPFW_OFS_STAT)) begin
                prdata_next = {31'h0, erased_reg};
            end else if (paddr != ADDR_W'(`GPFW_OFS_PROG)) begin
                pslverr_next = 1'b1;
            end
        end
    end

    // decode from the next word so outputs track the fuses with no lag
    always_comb begin
        logic [1:0] code;
        code = fuse_next[`GPFW_BRN_EN_HI:`GPFW_BRN_EN_LO];
        cfg_next.spare_fuses =
            fuse_next[`GPFW_SPARE_HI:`GPFW_SPARE_LO]; // [RULE9] [RULE10]
        // codes 0 and 3 both leave the detector off
        cfg_next.brownout_enable = (code == `GPFW_BRN_RST)
                                   || (code == `GPFW_BRN_NORST); // [RULE3]
        cfg_next.brownout_reset_enable = (code == `GPFW_BRN_RST); // [RULE3]
        cfg_next.brownout_hysteresis = fuse_next[`GPFW_HYST_BIT]; // [RULE4]
        cfg_next.brownout_trigger_level =
            fuse_next[`GPFW_LEVEL_HI:`GPFW_LEVEL_LO]; // [RULE5]
        cfg_next.boot_area_protect =
            fuse_next[`GPFW_BOOTP_HI:`GPFW_BOOTP_LO]; // [RULE6]
        cfg_next.ext_priv_fetch_lock = fuse_next[`GPFW_FLOCK_BIT]; // [RULE7]
        cfg_next.region_lock =
            fuse_next[`GPFW_LOCK_HI:`GPFW_LOCK_LO]; // [RULE8]
    end

    // reset stands for a fresh part; the fuses carry no other history
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= gpfw_pkg::GPFW_IDLE;
            fuse_reg    <= `GPFW_FUSE_SHIPPED; // [RULE2]
            erased_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
            pready_reg  <= 1'b0;
            cfg_reg     <= CFG_SHIPPED; // [RULE2]
        end else begin
            state_reg   <= state_next;
            fuse_reg    <= fuse_next;
            erased_reg  <= erased_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg  <= pready_next;
            cfg_reg     <= cfg_next; // [RULE10]
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign fuse_cfg = cfg_reg;

    sequence erase_seq;
        chip_erase;
    endsequence

    sequence all_ones_seq;
        fuse_reg == `GPFW_FUSE_ERASED;
    endsequence

    sequence flag_set_seq;
        erased_reg;
    endsequence

    property erase_p;
        @(posedge clk) disable iff (!reset_n)
            erase_seq |=> all_ones_seq;
    endproperty

    erase_all_a: assert property (erase_p) // [RULE1]
        else $error("erase did not set all fuses");

    erase_flag_a: assert property (@(posedge clk) // [RULE1]
        disable iff (!reset_n)
        erase_seq |=> flag_set_seq)
        else $error("erase did not set the erased flag");

    shipped_val_a: assert property (@(posedge clk) // [RULE2]
        $rose(reset_n) |-> fuse_reg == `GPFW_FUSE_SHIPPED
        && !fuse_cfg.brownout_enable)
        else $error("fuse word not shipped value after reset");

    brownout_decode_a: assert property (@(posedge clk) // [RULE3]
        disable iff (!reset_n)
        fuse_cfg.brownout_enable == (fuse_reg[28:27] == 2'h1
                                     || fuse_reg[28:27] == 2'h2)
        && fuse_cfg.brownout_reset_enable == (fuse_reg[28:27] == 2'h1))
        else $error("brownout enable decode wrong");

    hyst_bit_a: assert property (@(posedge clk) // [RULE4]
        disable iff (!reset_n)
        fuse_cfg.brownout_hysteresis == fuse_reg[26])
        else $error("hysteresis does not follow fuse");

    level_field_a: assert property (@(posedge clk) // [RULE5]
        disable iff (!reset_n)
        fuse_cfg.brownout_trigger_level == fuse_reg[25:20])
        else $error("trigger level does not follow fuse");

    boot_prot_a: assert property (@(posedge clk) // [RULE6]
        disable iff (!reset_n)
        fuse_cfg.boot_area_protect == fuse_reg[19:17])
        else $error("boot protect does not follow fuse");

    fetch_lock_a: assert property (@(posedge clk) // [RULE7]
        disable iff (!reset_n)
        fuse_cfg.ext_priv_fetch_lock == fuse_reg[16])
        else $error("fetch lock does not follow fuse");

    region_lock_a: assert property (@(posedge clk) // [RULE8]
        disable iff (!reset_n)
        fuse_cfg.region_lock == fuse_reg[15:0])
        else $error("region locks do not follow fuse");

    spare_read_a: assert property (@(posedge clk) // [RULE9]
        disable iff (!reset_n)
        (psel && penable && !pwrite
         && paddr == ADDR_W'(`GPFW_OFS_FUSE) && !pready)
        |=> pready && prdata[31:29] == $past(fuse_reg[31:29]))
        else $error("spare fuses not read back");

    // every raw field must match the word in the same cycle, never a lag
    cfg_track_a: assert property (@(posedge clk) // [RULE10]
        disable iff (!reset_n)
        (32'(fuse_cfg) & 32'he7ffffff) == (fuse_reg & 32'he7ffffff))
        else $error("configuration lags the fuse word");

    pready_pulse_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        pready |=> !pready)
        else $error("ready held for more than one cycle");

    prog_clear_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        wr_prog && !chip_erase
        |=> fuse_reg == ($past(fuse_reg) & $past(pwdata)))
        else $error("programming did not clear the chosen bits");
endmodule : gpfw_fuse_word

/* hdl/gpfw_consts.svh */
`ifndef GPFW_CONSTS_SVH
`define GPFW_CONSTS_SVH
`define GPFW_OFS_FUSE      8'h00
`define GPFW_OFS_PROG      8'h04
`define GPFW_OFS_STAT      8'h08
`define GPFW_FUSE_SHIPPED  32'hfc07ffff
`define GPFW_FUSE_ERASED   32'hffffffff
`define GPFW_SPARE_HI      31
`define GPFW_SPARE_LO      29
`define GPFW_BRN_EN_HI     28
`define GPFW_BRN_EN_LO     27
`define GPFW_HYST_BIT      26
`define GPFW_LEVEL_HI      25
`define GPFW_LEVEL_LO      20
`define GPFW_BOOTP_HI      19
`define GPFW_BOOTP_LO      17
`define GPFW_FLOCK_BIT     16
`define GPFW_LOCK_HI       15
`define GPFW_LOCK_LO       0
`define GPFW_BRN_OFF0      2'h0
`define GPFW_BRN_RST       2'h1
`define GPFW_BRN_NORST     2'h2
`define GPFW_BRN_OFF3      2'h3
`define GPFW_STAT_ERASED   0
`endif

/* hdl/gpfw_pkg.sv */
package gpfw_pkg;
    typedef enum logic [1:0] {
        GPFW_IDLE = 2'b01,
        GPFW_ACK  = 2'b10
    } gpfw_apb_state_t;

    typedef struct packed {
        logic [2:0]  spare_fuses;
        logic        brownout_enable;
        logic        brownout_reset_enable;
        logic        brownout_hysteresis;
        logic [5:0]  brownout_trigger_level;
        logic [2:0]  boot_area_protect;
        logic        ext_priv_fetch_lock;
        logic [15:0] region_lock;
    } gpfw_cfg_t;
endpackage : gpfw_pkg

/* verif/gpfw_fuse_word_tb_top.sv */
`timescale 1ns/100ps
`include "gpfw_consts.svh"
module gpfw_fuse_word_tb_top;
    logic                clk;
    logic                reset_n;
    logic                chip_erase;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    gpfw_pkg::gpfw_cfg_t fuse_cfg;
    int                  err_total = 0;
    int                  checked = 0;
    logic [31:0]         rd;
    logic                er;
    logic [31:0]         d1;
    logic [31:0]         d2;

    gpfw_fuse_word #(.ADDR_W(8)) u_dut (
        .clk(clk), .reset_n(reset_n), .chip_erase(chip_erase),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuse_cfg(fuse_cfg)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // decode kept apart from the design so a shared slip cannot hide
    function automatic gpfw_pkg::gpfw_cfg_t cfg_of(input logic [31:0] w);
        gpfw_pkg::gpfw_cfg_t c;
        c.spare_fuses         = w[31:29];
        c.brownout_enable        = (w[28:27] == 2'h1) || (w[28:27] == 2'h2);
        c.brownout_reset_enable  = (w[28:27] == 2'h1);
        c.brownout_hysteresis    = w[26];
        c.brownout_trigger_level = w[25:20];
        c.boot_area_protect   = w[19:17];
        c.ext_priv_fetch_lock = w[16];
        c.region_lock         = w[15:0];
        return c;
    endfunction : cfg_of

    task automatic chk(input string nm, input logic [63:0] s,
                       input logic [63:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // master waits for pready however long it takes; only the watchdog ends a wait that never sees it
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_word(input logic [31:0] exp);
        apb(1'b0, `GPFW_OFS_FUSE, 32'h0, rd, er);
        chk("fuse_word", 64'(rd), 64'(exp));
        chk("fuse_rd_err", 64'(er), 64'(1'b0));
        chk("fuse_cfg", 64'(fuse_cfg), 64'(cfg_of(exp)));
    endtask : check_word

    task automatic erase;
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
    endtask : erase

    task automatic close_out;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end

    initial begin
        reset_n = 1'b0; chip_erase = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        void'($urandom(58));
        check_word(`GPFW_FUSE_SHIPPED);
        apb(1'b1, `GPFW_OFS_FUSE, 32'h0, rd, er);
        chk("ro_write_err", 64'(er), 64'(1'b1));
        check_word(`GPFW_FUSE_SHIPPED);
        for (int c = 0; c < 4; c++) begin
            erase();
            d1 = {3'h7, c[1:0], 1'b0, 6'h2a, 4'hf, 16'h5a5a};
            apb(1'b1, `GPFW_OFS_PROG, d1, rd, er);
            check_word(d1);
        end
        for (int i = 0; i < 8; i++) begin
            erase();
            check_word(`GPFW_FUSE_ERASED);
            d1 = $urandom | $urandom;
            d2 = $urandom | $urandom;
            apb(1'b1, `GPFW_OFS_PROG, d1, rd, er);
            apb(1'b1, `GPFW_OFS_PROG, d2, rd, er);
            check_word(d1 & d2);
        end
        erase();
        apb(1'b0, `GPFW_OFS_STAT, 32'h0, rd, er);
        chk("erased_flag", 64'(rd), 64'(32'h1));
        apb(1'b1, `GPFW_OFS_STAT, 32'h1, rd, er);
        apb(1'b0, `GPFW_OFS_STAT, 32'h0, rd, er);
        chk("erased_clr", 64'(rd), 64'(32'h0));
        apb(1'b0, 8'h0c, 32'h0, rd, er);
        chk("unmapped_err", 64'({er, rd}), 64'({1'b1, 32'h0}));
        check_word(`GPFW_FUSE_ERASED);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        check_word(`GPFW_FUSE_SHIPPED);
        apb(1'b0, `GPFW_OFS_STAT, 32'h0, rd, er);
        chk("erased_rst", 64'(rd), 64'(32'h0));
        close_out();
    end
endmodule : gpfw_fuse_word_tb_top
